// [inc/oad_consts.svh]
// constants for the operand address decoder: codes, field positions, flags
// assumes inclusion by bare name from the design module and the bench
`ifndef OAD_CONSTS_SVH
`define OAD_CONSTS_SVH

// ************************************************************
// addressing form codes
// ************************************************************
`define OAD_MOD_NODISP  2'h0
`define OAD_MOD_DISP8   2'h1
`define OAD_MOD_DISP16  2'h2
`define OAD_MOD_REG     2'h3
`define OAD_RM_DIRECT   3'h6

// ************************************************************
// segment select codes
// ************************************************************
`define OAD_SEG_EXTRA   2'h0
`define OAD_SEG_CS      2'h1
`define OAD_SEG_SS      2'h2
`define OAD_SEG_DS      2'h3

// ************************************************************
// flag word bit positions
// ************************************************************
`define OAD_F_CARRY     0
`define OAD_F_PARITY    2
`define OAD_F_AUX       4
`define OAD_F_ZERO      6
`define OAD_F_SIGN      7
`define OAD_F_OVERFLOW  11

// ************************************************************
// instruction byte position of the first displacement byte
// ************************************************************
`define OAD_DISP_POS    3'h2
`endif

// [inc/oad_pkg.sv]
// types shared by the operand address decoder
// assumes nothing beyond the constants header
package oad_pkg;
   // operation requested with i_valid
   typedef enum logic [1:0] {
      OAD_OP_DECODE = 2'h0,  // address/register decode only
      OAD_OP_LOOKUP = 2'h1,  // table_lookup_op
      OAD_OP_XOR    = 2'h2,  // exclusive-or
      OAD_OP_ESC    = 2'h3   // coprocessor escape
   } oad_op_t;

   // shift_kind_field decode
   typedef enum logic [2:0] {
      OAD_ROTATE_LEFT             = 3'h0,
      OAD_ROTATE_RIGHT            = 3'h1,
      OAD_ROTATE_LEFT_THRU_CARRY  = 3'h2,
      OAD_ROTATE_RIGHT_THRU_CARRY = 3'h3,
      OAD_SHIFT_LEFT              = 3'h4,
      OAD_SHIFT_RIGHT_LOGICAL     = 3'h5,
      OAD_SHIFT_UNASSIGNED        = 3'h6,
      OAD_SHIFT_RIGHT_ARITH       = 3'h7
   } oad_shift_t;

   // control states, one-hot
   typedef enum logic [1:0] {
      OAD_ST_IDLE   = 2'h1,
      OAD_ST_LOOKUP = 2'h2
   } oad_state_t;
endpackage : oad_pkg

// [hdl/oad_core.sv]
// operand address decoder: effective address, segment, register and
// shift decode, plus the table lookup and exclusive-or datapaths
// assumes register values and memory read data come from same-clock logic
`timescale 1ns/1ns
`include "oad_consts.svh"

// Contract
// - lookup loads low accumulator from base plus index
// - lookup leaves every flag unchanged
// - exclusive-or writes dest xor src back
// - xor clears carry/overflow, sets sign/zero/parity
// - operand select picks the address register sum
// - form 00 select 110 is direct address
// - form 00 otherwise: zero displacement, none fetched
// - form 01 sign-extends byte; 10 takes word
// - form 11 makes operand select a register
// - displacement follows byte two, before immediates
// - frame pointer addressing defaults to stack segment
// - string destination uses extra segment for every op except lookup
// - byte register codes map low then high
// - shift kind field decodes seven shifts/rotates
// - escape fields pass to coprocessor as opcode
module oad_core
   import oad_pkg::*;
(
   // clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   // instruction request
   input  wire logic        i_valid,
   input  wire oad_op_t     i_op,
   input  wire logic [1:0]  i_mod,
   input  wire logic [2:0]  i_reg,
   input  wire logic [2:0]  i_rm,
   input  wire logic        i_w,
   input  wire logic [7:0]  i_disp_lo,
   input  wire logic [7:0]  i_disp_hi,
   input  wire logic        i_str_dst,
   input  wire logic        i_ovr_en,
   input  wire logic [1:0]  i_ovr_seg,
   // register file values
   input  wire logic [15:0] i_acc_word,
   input  wire logic [15:0] i_count_word,
   input  wire logic [15:0] i_data_word,
   input  wire logic [15:0] i_base_word,
   input  wire logic [15:0] i_stack_top_ptr,
   input  wire logic [15:0] i_frame_base_ptr,
   input  wire logic [15:0] i_src_index_ptr,
   input  wire logic [15:0] i_dst_index_ptr,
   input  wire logic [15:0] i_flags,
   // exclusive-or operands
   input  wire logic [15:0] i_xor_dst,
   input  wire logic [15:0] i_xor_src,
   // table read answer
   input  wire logic        i_rd_valid,
   input  wire logic [7:0]  i_rd_byte,
   // decode results
   output logic             o_done,
   output logic             o_busy,
   output logic [15:0]      o_operand_offset,
   output logic [1:0]       o_seg,
   output logic             o_rm_is_reg,
   output logic [1:0]       o_disp_bytes,
   output logic [2:0]       o_imm_pos,
   output logic [15:0]      o_reg_val,
   output logic [15:0]      o_rm_val,
   output oad_shift_t       o_shift_kind_field,
   output logic             o_shift_bad,
   output logic [5:0]       o_coproc_op,
   // execution results
   output logic             o_rd_req,
   output logic [15:0]      o_result,
   output logic             o_wr_acc_low,
   output logic             o_wr_dst,
   output logic [15:0]      o_flags
);

   // ************************************************************
   // register selection
   // ************************************************************
   // one mux serves both the reg field and the operand select field
   function automatic logic [15:0] pick_reg(input logic [2:0] code,
                                            input logic       wide);
      logic [15:0] v;
      v = 16'h0000;
      if (wide)
      begin
         unique case (code)
            3'h0: v = i_acc_word;
            3'h1: v = i_count_word;
            3'h2: v = i_data_word;
            3'h3: v = i_base_word;
            3'h4: v = i_stack_top_ptr;
            3'h5: v = i_frame_base_ptr;
            3'h6: v = i_src_index_ptr;
            3'h7: v = i_dst_index_ptr;
         endcase
      end
      else
      begin
         unique case (code)
            3'h0: v = {8'h00, i_acc_word[7:0]};
            3'h1: v = {8'h00, i_count_word[7:0]};
            3'h2: v = {8'h00, i_data_word[7:0]};
            3'h3: v = {8'h00, i_base_word[7:0]};
            3'h4: v = {8'h00, i_acc_word[15:8]};
            3'h5: v = {8'h00, i_count_word[15:8]};
            3'h6: v = {8'h00, i_data_word[15:8]};
            3'h7: v = {8'h00, i_base_word[15:8]};
         endcase
      end
      return v;
   endfunction : pick_reg

   // ************************************************************
   // state
   // ************************************************************
   oad_state_t  state_r, state_nxt;        // lookup sequencer
   logic        done_r, done_nxt;          // completion pulse
   logic [15:0] off_r, off_nxt;            // operand offset
   logic [1:0]  seg_r, seg_nxt;            // segment select
   logic        isreg_r, isreg_nxt;        // operand is a register
   logic [1:0]  dbytes_r, dbytes_nxt;      // displacement byte count
   logic [2:0]  imm_r, imm_nxt;            // immediate byte position
   logic [15:0] regv_r, regv_nxt;          // reg field value
   logic [15:0] rmv_r, rmv_nxt;            // operand select register value
   oad_shift_t  shk_r, shk_nxt;            // shift kind
   logic        shbad_r, shbad_nxt;        // unassigned shift code
   logic [5:0]  cop_r, cop_nxt;            // coprocessor opcode
   logic        rdreq_r, rdreq_nxt;        // table read request
   logic [15:0] res_r, res_nxt;            // result word
   logic        wacc_r, wacc_nxt;          // low accumulator write
   logic        wdst_r, wdst_nxt;          // destination write
   logic [15:0] flg_r, flg_nxt;            // flag word out

   // combinational helpers
   logic [15:0] addr_sum;                  // register sum part
   logic [15:0] disp;                      // displacement
   logic        uses_frame;                // frame pointer in address
   logic [15:0] xr;                        // xor result

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb
   begin
      // address register sum by operand select
      unique case (i_rm)
         3'h0: addr_sum = i_base_word + i_src_index_ptr;
         3'h1: addr_sum = i_base_word + i_dst_index_ptr;
         3'h2: addr_sum = i_frame_base_ptr + i_src_index_ptr;
         3'h3: addr_sum = i_frame_base_ptr + i_dst_index_ptr;
         3'h4: addr_sum = i_src_index_ptr;
         3'h5: addr_sum = i_dst_index_ptr;
         3'h6: addr_sum = i_frame_base_ptr;
         3'h7: addr_sum = i_base_word;
      endcase
      // displacement by addressing form
      unique case (i_mod)
         `OAD_MOD_DISP8:  disp = {{8{i_disp_lo[7]}}, i_disp_lo};
         `OAD_MOD_DISP16: disp = {i_disp_hi, i_disp_lo};
         default:         disp = 16'h0000;
      endcase
      uses_frame = (i_mod != `OAD_MOD_REG) &&
                   ((i_rm == 3'h2) || (i_rm == 3'h3) ||
                    ((i_rm == `OAD_RM_DIRECT) && (i_mod != `OAD_MOD_NODISP)));
      xr = i_w ? (i_xor_dst ^ i_xor_src)
               : {8'h00, i_xor_dst[7:0] ^ i_xor_src[7:0]};

      // defaults: hold, pulses low
      state_nxt  = state_r;
      done_nxt   = 1'b0;
      off_nxt    = off_r;
      seg_nxt    = seg_r;
      isreg_nxt  = isreg_r;
      dbytes_nxt = dbytes_r;
      imm_nxt    = imm_r;
      regv_nxt   = regv_r;
      rmv_nxt    = rmv_r;
      shk_nxt    = shk_r;
      shbad_nxt  = shbad_r;
      cop_nxt    = cop_r;
      rdreq_nxt  = rdreq_r;
      res_nxt    = res_r;
      wacc_nxt   = 1'b0;
      wdst_nxt   = 1'b0;
      flg_nxt    = flg_r;

      unique case (state_r)
         OAD_ST_IDLE:
         begin
            if (i_valid)
            begin
               // operand offset
               if (i_mod == `OAD_MOD_NODISP && i_rm == `OAD_RM_DIRECT)
                  off_nxt = {i_disp_hi, i_disp_lo};
               else
                  off_nxt = addr_sum + disp;
               isreg_nxt = (i_mod == `OAD_MOD_REG);
               // displacement bytes expected after byte two
               unique case (i_mod)
                  `OAD_MOD_NODISP: dbytes_nxt =
                     (i_rm == `OAD_RM_DIRECT) ? 2'h2 : 2'h0;
                  `OAD_MOD_DISP8:  dbytes_nxt = 2'h1;
                  `OAD_MOD_DISP16: dbytes_nxt = 2'h2;
                  `OAD_MOD_REG:    dbytes_nxt = 2'h0;
               endcase
               // immediates follow the displacement bytes
               imm_nxt = `OAD_DISP_POS + {1'b0, dbytes_nxt};
               // segment: string destination beats everything except the lookup op
               if (i_str_dst)
                  seg_nxt = `OAD_SEG_EXTRA;
               else if (i_ovr_en)
                  seg_nxt = i_ovr_seg;
               else if (uses_frame)
                  seg_nxt = `OAD_SEG_SS;
               else
                  seg_nxt = `OAD_SEG_DS;
               regv_nxt  = pick_reg(i_reg, i_w);
               rmv_nxt   = pick_reg(i_rm, i_w);
               shk_nxt   = oad_shift_t'(i_reg);
               shbad_nxt = (i_reg == OAD_SHIFT_UNASSIGNED);
               unique case (i_op)
                  OAD_OP_LOOKUP:
                  begin
                     // table may wrap within the 64 KiB offset space
                     off_nxt   = i_base_word + {8'h00, i_acc_word[7:0]};
                     seg_nxt   = i_ovr_en ? i_ovr_seg : `OAD_SEG_DS;
                     rdreq_nxt = 1'b1;
                     state_nxt = OAD_ST_LOOKUP;
                  end
                  OAD_OP_XOR:
                  begin
                     res_nxt  = xr;
                     wdst_nxt = 1'b1;
                     done_nxt = 1'b1;
                     flg_nxt  = i_flags;
                     flg_nxt[`OAD_F_CARRY]    = 1'b0;
                     flg_nxt[`OAD_F_OVERFLOW] = 1'b0;
                     flg_nxt[`OAD_F_SIGN]     = i_w ? xr[15] : xr[7];
                     flg_nxt[`OAD_F_ZERO]     = (xr == 16'h0000);
                     flg_nxt[`OAD_F_PARITY]   = ~^xr[7:0];
                     // aux carry is undefined; held as it was
                  end
                  OAD_OP_ESC:
                  begin
                     cop_nxt  = {i_reg, i_rm};
                     done_nxt = 1'b1;
                     flg_nxt  = i_flags;
                  end
                  default:
                  begin
                     done_nxt = 1'b1;
                     flg_nxt  = i_flags;
                  end
               endcase
            end
         end
         OAD_ST_LOOKUP:
         begin
            // wait for the table byte; the flags pass through untouched
            if (i_rd_valid)
            begin
               res_nxt   = {i_acc_word[15:8], i_rd_byte};
               wacc_nxt  = 1'b1;
               flg_nxt   = i_flags;
               rdreq_nxt = 1'b0;
               done_nxt  = 1'b1;
               state_nxt = OAD_ST_IDLE;
            end
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   // clock enable low freezes everything, including pulses
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r  <= OAD_ST_IDLE;
         done_r   <= 1'b0;
         off_r    <= 16'h0000;
         seg_r    <= `OAD_SEG_DS;
         isreg_r  <= 1'b0;
         dbytes_r <= 2'h0;
         imm_r    <= `OAD_DISP_POS;
         regv_r   <= 16'h0000;
         rmv_r    <= 16'h0000;
         shk_r    <= OAD_ROTATE_LEFT;
         shbad_r  <= 1'b0;
         cop_r    <= 6'h00;
         rdreq_r  <= 1'b0;
         res_r    <= 16'h0000;
         wacc_r   <= 1'b0;
         wdst_r   <= 1'b0;
         flg_r    <= 16'h0000;
      end
      else if (i_ce)
      begin
         state_r  <= state_nxt;
         done_r   <= done_nxt;
         off_r    <= off_nxt;
         seg_r    <= seg_nxt;
         isreg_r  <= isreg_nxt;
         dbytes_r <= dbytes_nxt;
         imm_r    <= imm_nxt;
         regv_r   <= regv_nxt;
         rmv_r    <= rmv_nxt;
         shk_r    <= shk_nxt;
         shbad_r  <= shbad_nxt;
         cop_r    <= cop_nxt;
         rdreq_r  <= rdreq_nxt;
         res_r    <= res_nxt;
         wacc_r   <= wacc_nxt;
         wdst_r   <= wdst_nxt;
         flg_r    <= flg_nxt;
      end
   end

   // output wiring
   assign o_done             = done_r;
   assign o_busy             = (state_r == OAD_ST_LOOKUP);
   assign o_operand_offset   = off_r;
   assign o_seg              = seg_r;
   assign o_rm_is_reg        = isreg_r;
   assign o_disp_bytes       = dbytes_r;
   assign o_imm_pos          = imm_r;
   assign o_reg_val          = regv_r;
   assign o_rm_val           = rmv_r;
   assign o_shift_kind_field = shk_r;
   assign o_shift_bad        = shbad_r;
   assign o_coproc_op        = cop_r;
   assign o_rd_req           = rdreq_r;
   assign o_result           = res_r;
   assign o_wr_acc_low       = wacc_r;
   assign o_wr_dst           = wdst_r;
   assign o_flags            = flg_r;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   logic go;
   assign go = i_ce && i_valid && (state_r == OAD_ST_IDLE);

   property p_lookup_res;
      i_ce && i_rd_valid && o_busy |=> o_wr_acc_low &&
         o_result[7:0] == $past(i_rd_byte) && o_flags == $past(i_flags) &&
         o_result[15:8] == $past(i_acc_word[15:8]);
   endproperty
   a_lookup_res: assert property (p_lookup_res) else $error("lookup result bad");

   property p_lookup_addr;
      go && i_op == OAD_OP_LOOKUP |=> o_rd_req &&
         o_operand_offset == $past(i_base_word) + {8'h00, $past(i_acc_word[7:0])};
   endproperty
   a_lookup_addr: assert property (p_lookup_addr) else $error("lookup address");

   property p_xor;
      go && i_op == OAD_OP_XOR && i_w |=> o_wr_dst &&
         o_result == ($past(i_xor_dst) ^ $past(i_xor_src));
   endproperty
   a_xor: assert property (p_xor) else $error("xor result bad");

   property p_xor_flags;
      go && i_op == OAD_OP_XOR |=> !o_flags[`OAD_F_CARRY] &&
         !o_flags[`OAD_F_OVERFLOW] && o_flags[`OAD_F_ZERO] == (o_result == 16'h0000);
   endproperty
   a_xor_flags: assert property (p_xor_flags) else $error("xor flags bad");

   property p_direct;
      go && i_op == OAD_OP_DECODE && i_mod == 2'h0 && i_rm == 3'h6 |=>
         o_operand_offset == {$past(i_disp_hi), $past(i_disp_lo)} && o_disp_bytes == 2'h2;
   endproperty
   a_direct: assert property (p_direct) else $error("direct address bad");

   property p_nodisp;
      go && i_op == OAD_OP_DECODE && i_mod == 2'h0 && i_rm == 3'h7 |=>
         o_operand_offset == $past(i_base_word) && o_imm_pos == 3'h2;
   endproperty
   a_nodisp: assert property (p_nodisp) else $error("zero disp bad");

   property p_disp8;
      go && i_op == OAD_OP_DECODE && i_mod == 2'h1 && i_rm == 3'h4 |=>
         o_operand_offset == $past(i_src_index_ptr) +
            {{8{$past(i_disp_lo[7])}}, $past(i_disp_lo)} && o_imm_pos == 3'h3;
   endproperty
   a_disp8: assert property (p_disp8) else $error("byte disp bad");

   property p_estr;
      go && i_str_dst |=> o_seg == 2'h0;
   endproperty
   a_estr: assert property (p_estr) else $error("string segment bad");

   property p_frame;
      go && i_op == OAD_OP_DECODE && !i_str_dst && !i_ovr_en &&
         i_mod == 2'h1 && i_rm == 3'h6 |=> o_seg == 2'h2;
   endproperty
   a_frame: assert property (p_frame) else $error("frame segment bad");

   property p_esc;
      go && i_op == OAD_OP_ESC |=> o_coproc_op == {$past(i_reg), $past(i_rm)} ##1 1'b1;
   endproperty
   a_esc: assert property (p_esc) else $error("escape opcode bad");

   c_lookup: cover property (go && i_op == OAD_OP_LOOKUP ##[1:20] o_wr_acc_low);
   c_xor:  cover property (go && i_op == OAD_OP_XOR ##1 o_flags[`OAD_F_ZERO]);
   c_reg:  cover property (go && i_mod == 2'h3 ##1 o_rm_is_reg);
endmodule : oad_core

// [tb/oad_core_tb.sv]
// self-checking bench for the operand address decoder core
// assumes the core's one clock domain and that the bench stands in for all register sources
`timescale 1ns/1ns
`include "oad_consts.svh"

module oad_core_tb
   import oad_pkg::*;
;
   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   logic        i_clk, i_rst, i_ce, i_valid, i_w, i_str_dst, i_ovr_en, i_rd_valid;
   oad_op_t     i_op;
   logic [1:0]  i_mod, i_ovr_seg, o_seg, o_disp_bytes;
   logic [2:0]  i_reg, i_rm, o_imm_pos;
   logic [7:0]  i_disp_lo, i_disp_hi, i_rd_byte;
   logic [15:0] i_flags, i_xor_dst, i_xor_src, o_operand_offset, o_reg_val, o_rm_val;
   logic [15:0] o_result, o_flags;
   logic [15:0] rv [8];                      // register file image, index = word code
   logic        o_done, o_busy, o_rm_is_reg, o_shift_bad, o_rd_req, o_wr_acc_low, o_wr_dst;
   logic [5:0]  o_coproc_op;
   oad_shift_t  o_shift_kind_field;
   int          failures = 0;                // mismatches seen
   int          checks_done = 0;             // comparisons made

   oad_core oad_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_valid(i_valid),
      .i_op(i_op), .i_mod(i_mod), .i_reg(i_reg), .i_rm(i_rm), .i_w(i_w),
      .i_disp_lo(i_disp_lo), .i_disp_hi(i_disp_hi), .i_str_dst(i_str_dst),
      .i_ovr_en(i_ovr_en), .i_ovr_seg(i_ovr_seg), .i_acc_word(rv[0]), .i_count_word(rv[1]),
      .i_data_word(rv[2]), .i_base_word(rv[3]), .i_stack_top_ptr(rv[4]),
      .i_frame_base_ptr(rv[5]), .i_src_index_ptr(rv[6]), .i_dst_index_ptr(rv[7]),
      .i_flags(i_flags), .i_xor_dst(i_xor_dst), .i_xor_src(i_xor_src),
      .i_rd_valid(i_rd_valid), .i_rd_byte(i_rd_byte), .o_done(o_done), .o_busy(o_busy),
      .o_operand_offset(o_operand_offset), .o_seg(o_seg), .o_rm_is_reg(o_rm_is_reg),
      .o_disp_bytes(o_disp_bytes), .o_imm_pos(o_imm_pos), .o_reg_val(o_reg_val),
      .o_rm_val(o_rm_val), .o_shift_kind_field(o_shift_kind_field),
      .o_shift_bad(o_shift_bad), .o_coproc_op(o_coproc_op), .o_rd_req(o_rd_req),
      .o_result(o_result), .o_wr_acc_low(o_wr_acc_low), .o_wr_dst(o_wr_dst),
      .o_flags(o_flags));

   // ************************************************************
   // clock, 100 ns period
   // ************************************************************
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // ************************************************************
   // shared helpers
   // ************************************************************
   // verdict in one place, reached by the main sequence and by any timeout
   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // bounded wait for the done pulse; strobes drop at the first edge so each is one cycle
   task automatic wait_done;
      for (int n = 0; n < 20; n++)
      begin
         @(posedge i_clk);
         i_valid    <= 1'b0;
         i_rd_valid <= 1'b0;
         #1;
         if (o_done === 1'b1) return;
      end
      failures++;
      end_sim();
   endtask : wait_done

   // present one request on a rising edge, then wait for its answer
   task automatic go(input oad_op_t op, input logic [1:0] md, input logic [2:0] rg,
                     input logic [2:0] rm, input logic w, input logic sd, input logic oe,
                     input logic [1:0] os);
      @(posedge i_clk);
      i_op <= op; i_mod <= md; i_reg <= rg; i_rm <= rm; i_w <= w;
      i_str_dst <= sd; i_ovr_en <= oe; i_ovr_seg <= os; i_valid <= 1'b1;
      wait_done();
   endtask : go

   // register value for a field code; byte codes pick low bytes then high bytes
   function automatic logic [15:0] regv(input logic [2:0] c, input logic w);
      if (w) return rv[c];
      return c[2] ? {8'h00, rv[c[1:0]][15:8]} : {8'h00, rv[c[1:0]][7:0]};
   endfunction : regv

   // ************************************************************
   // scenarios
   // ************************************************************
   // every form 00/01/10 with every operand select, displacement byte negative
   task automatic t_memory_forms;
      logic [15:0] eo, d;
      logic [1:0]  nb;
      for (int m = 0; m < 3; m++)
         for (int r = 0; r < 8; r++)
         begin
            go(OAD_OP_DECODE, m[1:0], 3'h0, r[2:0], 1'b1, 1'b0, 1'b0, 2'h0);
            case (r)
               0: eo = rv[3] + rv[6];
               1: eo = rv[3] + rv[7];
               2: eo = rv[5] + rv[6];
               3: eo = rv[5] + rv[7];
               4: eo = rv[6];
               5: eo = rv[7];
               6: eo = rv[5];
               default: eo = rv[3];
            endcase
            d  = (m == 1) ? {{8{i_disp_lo[7]}}, i_disp_lo} : {i_disp_hi, i_disp_lo};
            nb = (m == 0) ? ((r == 6) ? 2'h2 : 2'h0) : ((m == 1) ? 2'h1 : 2'h2);
            if (m == 0) eo = (r == 6) ? {i_disp_hi, i_disp_lo} : eo;
            else eo = eo + d;
            chk(o_operand_offset, eo);
            chk(o_disp_bytes, nb);
            chk(o_imm_pos, 3'h2 + nb);
            chk(o_rm_is_reg, 1'b0);
            chk(o_seg, (r == 2 || r == 3 || (r == 6 && m != 0)) ? 2'h2 : 2'h3);
         end
   endtask : t_memory_forms

   // form 11, both widths, all codes; reg field also read as shift kind
   task automatic t_register_form;
      for (int w = 0; w < 2; w++)
         for (int c = 0; c < 8; c++)
         begin
            go(OAD_OP_DECODE, 2'h3, c[2:0], 3'h7 - c[2:0], w[0], 1'b0, 1'b0, 2'h0);
            chk(o_rm_is_reg, 1'b1);
            chk(o_reg_val, regv(c[2:0], w[0]));
            chk(o_rm_val, regv(3'h7 - c[2:0], w[0]));
            chk(o_shift_kind_field, c[2:0]);
            chk(o_shift_bad, c == 6);
         end
   endtask : t_register_form

   // string destination keeps extra segment even under an override prefix
   task automatic t_segments;
      go(OAD_OP_DECODE, 2'h1, 3'h0, 3'h5, 1'b1, 1'b1, 1'b1, 2'h2);
      chk(o_seg, 2'h0);
      go(OAD_OP_DECODE, 2'h1, 3'h0, 3'h2, 1'b1, 1'b0, 1'b1, 2'h1);
      chk(o_seg, 2'h1);
      go(OAD_OP_ESC, 2'h0, 3'h5, 3'h2, 1'b0, 1'b0, 1'b0, 2'h0);
      chk(o_coproc_op, 6'h2a);
   endtask : t_segments

   // table lookup with the answer held back a few cycles
   task automatic t_lookup;
      go_lookup_start();
      chk(o_busy, 1'b1);
      chk(o_rd_req, 1'b1);
      chk(o_operand_offset, rv[3] + {8'h00, rv[0][7:0]});
      repeat (3) @(posedge i_clk);
      i_rd_byte  <= 8'h33;
      i_rd_valid <= 1'b1;
      wait_done();
      chk(o_wr_acc_low, 1'b1);
      chk(o_result, {rv[0][15:8], 8'h33});
      chk(o_flags, i_flags);
      chk(o_busy, 1'b0);
      chk(o_rd_req, 1'b0);
      chk(o_wr_dst, 1'b0);
   endtask : t_lookup

   task automatic go_lookup_start;
      @(posedge i_clk);
      i_op    <= OAD_OP_LOOKUP;
      i_valid <= 1'b1;
      @(posedge i_clk);
      i_valid <= 1'b0;
      #1;
   endtask : go_lookup_start

   // exclusive-or, word with sign set then byte with zero result
   task automatic t_xor;
      logic [15:0] r, f;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge i_clk);
         i_xor_dst <= k ? 16'h12aa : 16'h8f0f;
         i_xor_src <= k ? 16'h34aa : 16'h0f0f;
         #1;
         r = k ? 16'h0000 : 16'h8000;
         f = i_flags;
         f[`OAD_F_CARRY] = 1'b0;
         f[`OAD_F_OVERFLOW] = 1'b0;
         f[`OAD_F_SIGN] = k ? 1'b0 : 1'b1;
         f[`OAD_F_ZERO] = k ? 1'b1 : 1'b0;
         f[`OAD_F_PARITY] = ~^r[7:0];
         go(OAD_OP_XOR, 2'h3, 3'h0, 3'h0, ~k[0], 1'b0, 1'b0, 2'h0);
         chk(o_result, r);
         chk(o_wr_dst, 1'b1);
         chk(o_flags, f);
         chk(o_wr_acc_low, 1'b0);
      end
   endtask : t_xor

   // enable low: a held request is not taken until enable returns
   task automatic t_freeze;
      @(posedge i_clk);
      i_ce    <= 1'b0;
      i_op    <= OAD_OP_DECODE;
      i_mod   <= 2'h3;
      i_valid <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      chk(o_done, 1'b0);
      chk(o_rm_is_reg, 1'b0);
      @(posedge i_clk);
      i_ce <= 1'b1;
      wait_done();
      chk(o_rm_is_reg, 1'b1);
   endtask : t_freeze

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      i_rst = 1'b1; i_ce = 1'b1; i_valid = 1'b0; i_op = OAD_OP_DECODE; i_mod = 2'h0;
      i_reg = 3'h0; i_rm = 3'h0; i_w = 1'b0; i_disp_lo = 8'h94; i_disp_hi = 8'h12;
      i_str_dst = 1'b0; i_ovr_en = 1'b0; i_ovr_seg = 2'h0; i_rd_valid = 1'b0;
      i_rd_byte = 8'h00; i_flags = 16'h0fd5; i_xor_dst = 16'h0000; i_xor_src = 16'h0000;
      rv = '{16'h12a5, 16'h3344, 16'h5566, 16'h7000, 16'h9988, 16'ha000, 16'h0100, 16'h0020};
      repeat (5) @(posedge i_clk);
      #1;
      chk(o_seg, 2'h3);
      chk(o_imm_pos, 3'h2);
      @(posedge i_clk);
      i_rst <= 1'b0;
      t_memory_forms();
      t_register_form();
      t_segments();
      t_lookup();
      t_freeze();
      t_xor();
      end_sim();
   end
endmodule : oad_core_tb
